// file: pmr_consts.vh
// Constants for the management register bank and its serial management port
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH

// ==========================================================================
// Register addresses and the PHY address zero
`define PMR_REG_CTRL 5'h00
`define PMR_REG_EVT 5'h1f
`define PMR_ADDR_ZERO 5'h00

// ==========================================================================
// Basic control register fields
`define PMR_B_RST 15
`define PMR_B_LOOP 14
`define PMR_B_RATE 13
`define PMR_B_ANEN 12
`define PMR_B_LPWR 11
`define PMR_B_ISO 10
`define PMR_B_ANRS 9
`define PMR_B_DPX 8
`define PMR_B_COLT 7
`define PMR_CTRL_DFLT 16'h3000
`define PMR_CTRL_WMASK 16'h7d80
`define PMR_CTRL_ISO_SET 16'h0400

// ==========================================================================
// Event register fields
`define PMR_EV_LATCH_HIGH 15
`define PMR_EV_LATCH_LOW 14
`define PMR_MX_W 3
`define PMR_EV_MX_HI 2
`define PMR_EV_MX_LO 0

// ==========================================================================
// Latching cell kinds
`define PMR_MODE_LATCH_HIGH 0
`define PMR_MODE_LATCH_LOW 1
`define PMR_MODE_MX 2

// ==========================================================================
// Serial frame layout
`define PMR_PRE_LEN 6'd32
`define PMR_HDR_LAST 5'd13
`define PMR_DATA_LAST 5'd15
`define PMR_FRM_ST 2'b01
`define PMR_OP_RD 2'b10
`define PMR_OP_WR 2'b01

// ==========================================================================
// Timing
`define PMR_CLK_NS 25
`define PMR_SRST_NS 2000
`define PMR_SRST_CYC ((`PMR_SRST_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)
`define PMR_STRAP_WAIT 2'd2

`endif

// file: pmr_latch_cell.v
// Latching status cell: latch-high, latch-low or latched-maximum group
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"

module pmr_latch_cell #(
  parameter W = 1,
  parameter MODE = `PMR_MODE_LATCH_HIGH
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [W-1:0] live,
  input wire reload,
  input wire init,
  output reg [W-1:0] val_r
);

  localparam [W-1:0] DFLT = (MODE == `PMR_MODE_LATCH_LOW) ? {W{1'b1}} : {W{1'b0}};

  // ========================================================================
  // Capture and reload
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      val_r <= DFLT;
    end else if (init) begin
      val_r <= DFLT;
    end else if (reload) begin
      // Live level wins, so an event in the read cycle is kept
      val_r <= live;
    end else begin
      case (MODE)
        `PMR_MODE_LATCH_HIGH: val_r <= val_r | live;
        `PMR_MODE_LATCH_LOW: val_r <= val_r & live;
        default: begin
          if (live > val_r) begin
            val_r <= live;
          end
        end
      endcase
    end
  end

endmodule // pmr_latch_cell

`default_nettype wire

// file: pmr_mgmt_regs.v
// Management register bank with serial management port, control register and latching bits
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"

module pmr_mgmt_regs (
  input wire sys_clk,
  input wire arst_n,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out_r,
  output reg mdio_oe_r,
  input wire [4:0] phy_addr_pin,
  input wire ev_high,
  input wire ev_low_n,
  input wire [`PMR_MX_W-1:0] sm_state,
  input wire an_started,
  input wire [3:0] mac_txd,
  input wire mac_tx_en,
  input wire mac_tx_er,
  output reg [3:0] lb_rxd_r,
  output reg lb_rx_dv_r,
  output reg lb_rx_er_r,
  output wire loop_en,
  output wire tp_tx_en,
  output wire tp_rx_en,
  output wire col_det_en,
  output wire speed_100,
  output wire an_enable,
  output wire low_power,
  output wire isolate,
  output wire duplex_full,
  output wire an_restart_req,
  output wire soft_reset
);

  localparam [2:0] S_PRE = 3'd0;
  localparam [2:0] S_HDR = 3'd1;
  localparam [2:0] S_TA = 3'd2;
  localparam [2:0] S_DAT = 3'd3;
  localparam integer SRST_CYC = `PMR_SRST_CYC;

  function [15:0] ctrl_default;
    input [4:0] addr;
    begin
      ctrl_default = (addr == `PMR_ADDR_ZERO) ?
        (`PMR_CTRL_DFLT | `PMR_CTRL_ISO_SET) : `PMR_CTRL_DFLT;
    end
  endfunction

  // ========================================================================
  // Pin synchronisers
  reg mdc_s1_r, mdc_s2_r, mdc_s3_r;
  reg mdio_s1_r, mdio_s2_r;
  reg [4:0] pa_s1_r, pa_s2_r;
  wire mdc_rise = mdc_s2_r & ~mdc_s3_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_s3_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
      pa_s1_r <= 5'h00;
      pa_s2_r <= 5'h00;
    end else begin
      mdc_s1_r <= mdc;
      mdc_s2_r <= mdc_s1_r;
      mdc_s3_r <= mdc_s2_r;
      mdio_s1_r <= mdio_in;
      mdio_s2_r <= mdio_s1_r;
      pa_s1_r <= phy_addr_pin;
      pa_s2_r <= pa_s1_r;
    end
  end

  // ========================================================================
  // Serial frame engine
  reg [2:0] st_r;
  reg [5:0] pre_cnt_r;
  reg [4:0] bit_cnt_r;
  reg [15:0] sh_r;
  reg [4:0] reg_sel_r;
  reg is_rd_r;
  reg rd_cap_r;
  reg wr_done_r;
  reg strap_done_r;
  reg [4:0] strap_addr_r;
  wire [13:0] hdr_w = {sh_r[12:0], mdio_s2_r};
  wire hdr_ok = (hdr_w[13:12] == `PMR_FRM_ST) && (hdr_w[9:5] == strap_addr_r) &&
    ((hdr_w[11:10] == `PMR_OP_RD) || (hdr_w[11:10] == `PMR_OP_WR)) && strap_done_r;
  reg [15:0] rd_word;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= S_PRE;
      pre_cnt_r <= 6'd0;
      bit_cnt_r <= 5'd0;
      sh_r <= 16'h0000;
      reg_sel_r <= 5'h00;
      is_rd_r <= 1'b0;
      rd_cap_r <= 1'b0;
      wr_done_r <= 1'b0;
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
    end else begin
      rd_cap_r <= 1'b0;
      wr_done_r <= 1'b0;
      if (mdc_rise) begin
        case (st_r)
          S_PRE: begin
            if (mdio_s2_r) begin
              if (pre_cnt_r != `PMR_PRE_LEN) begin
                pre_cnt_r <= pre_cnt_r + 6'd1;
              end
            end else begin
              if (pre_cnt_r == `PMR_PRE_LEN) begin
                st_r <= S_HDR;
                sh_r <= 16'h0000;
                bit_cnt_r <= 5'd1;
              end
              pre_cnt_r <= 6'd0;
            end
          end
          S_HDR: begin
            sh_r <= {sh_r[14:0], mdio_s2_r};
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (bit_cnt_r == `PMR_HDR_LAST) begin
              bit_cnt_r <= 5'd0;
              reg_sel_r <= hdr_w[4:0];
              is_rd_r <= (hdr_w[11:10] == `PMR_OP_RD);
              st_r <= hdr_ok ? S_TA : S_PRE;
            end
          end
          S_TA: begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (is_rd_r) begin
              if (bit_cnt_r == 5'd0) begin
                mdio_oe_r <= 1'b1;
                mdio_out_r <= 1'b0;
              end else begin
                sh_r <= rd_word;
                mdio_out_r <= rd_word[15];
                rd_cap_r <= 1'b1;
                st_r <= S_DAT;
                bit_cnt_r <= 5'd0;
              end
            end else if (bit_cnt_r != 5'd0) begin
              st_r <= S_DAT;
              bit_cnt_r <= 5'd0;
            end
          end
          default: begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (is_rd_r) begin
              if (bit_cnt_r == `PMR_DATA_LAST) begin
                mdio_oe_r <= 1'b0;
                mdio_out_r <= 1'b0;
                st_r <= S_PRE;
              end else begin
                sh_r <= {sh_r[14:0], 1'b0};
                mdio_out_r <= sh_r[14];
              end
            end else begin
              sh_r <= {sh_r[14:0], mdio_s2_r};
              if (bit_cnt_r == `PMR_DATA_LAST) begin
                wr_done_r <= 1'b1;
                st_r <= S_PRE;
              end
            end
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Basic control register
  reg [15:0] ctrl_r;
  reg an_restart_r;
  reg srst_busy_r;
  reg [7:0] srst_cnt_r;
  reg [1:0] strap_cnt_r;
  wire ctrl_wr = wr_done_r && (reg_sel_r == `PMR_REG_CTRL) && !srst_busy_r;
  wire lp_enter = ctrl_wr && sh_r[`PMR_B_LPWR] && !ctrl_r[`PMR_B_LPWR];
  wire latch_init = lp_enter || srst_busy_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `PMR_CTRL_DFLT;
      an_restart_r <= 1'b0;
      srst_busy_r <= 1'b0;
      srst_cnt_r <= 8'h00;
      strap_cnt_r <= 2'd0;
      strap_done_r <= 1'b0;
      strap_addr_r <= 5'h00;
    end else begin
      // Strap is read only after the synchroniser has filled past reset release
      if (!strap_done_r) begin
        if (strap_cnt_r == `PMR_STRAP_WAIT) begin
          strap_done_r <= 1'b1;
          strap_addr_r <= pa_s2_r;
          ctrl_r <= ctrl_default(pa_s2_r);
        end else begin
          strap_cnt_r <= strap_cnt_r + 2'd1;
        end
      end
      if (srst_busy_r) begin
        ctrl_r <= ctrl_default(strap_addr_r);
        an_restart_r <= 1'b0;
        if (srst_cnt_r == 8'h00) begin
          srst_busy_r <= 1'b0;
        end else begin
          srst_cnt_r <= srst_cnt_r - 8'h01;
        end
      end else begin
        if (an_restart_r && an_started) begin
          an_restart_r <= 1'b0;
        end
        if (ctrl_wr) begin
          if (sh_r[`PMR_B_RST]) begin
            srst_busy_r <= 1'b1;
            srst_cnt_r <= SRST_CYC[7:0];
          end else begin
            // Reserved bits are masked out and never stored
            ctrl_r <= sh_r & `PMR_CTRL_WMASK;
            if (sh_r[`PMR_B_ANRS] && ctrl_r[`PMR_B_ANEN]) begin
              an_restart_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ========================================================================
  // Latching status cells
  wire ev_reload = rd_cap_r && (reg_sel_r == `PMR_REG_EVT);
  wire hi_val, lo_val;
  wire [`PMR_MX_W-1:0] mx_val;

  pmr_latch_cell #(.W(1), .MODE(`PMR_MODE_LATCH_HIGH)) u_hi_latch (
    .sys_clk(sys_clk), .arst_n(arst_n), .live(ev_high), .reload(ev_reload),
    .init(latch_init), .val_r(hi_val)
  );

  pmr_latch_cell #(.W(1), .MODE(`PMR_MODE_LATCH_LOW)) u_lo_latch (
    .sys_clk(sys_clk), .arst_n(arst_n), .live(ev_low_n), .reload(ev_reload),
    .init(latch_init), .val_r(lo_val)
  );

  pmr_latch_cell #(.W(`PMR_MX_W), .MODE(`PMR_MODE_MX)) u_mx (
    .sys_clk(sys_clk), .arst_n(arst_n), .live(sm_state), .reload(ev_reload),
    .init(srst_busy_r), .val_r(mx_val)
  );

  // ========================================================================
  // Read data
  always @* begin
    rd_word = 16'h0000;
    if (reg_sel_r == `PMR_REG_CTRL) begin
      rd_word = ctrl_r;
      rd_word[`PMR_B_RST] = srst_busy_r;
      rd_word[`PMR_B_ANRS] = an_restart_r;
    end else if (reg_sel_r == `PMR_REG_EVT) begin
      rd_word[`PMR_EV_LATCH_HIGH] = hi_val;
      rd_word[`PMR_EV_LATCH_LOW] = lo_val;
      rd_word[`PMR_EV_MX_HI:`PMR_EV_MX_LO] = mx_val;
    end
  end

  // ========================================================================
  // Loopback path
  // One register stage, far inside the 512 bit time limit at either rate
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lb_rxd_r <= 4'h0;
      lb_rx_dv_r <= 1'b0;
      lb_rx_er_r <= 1'b0;
    end else begin
      lb_rxd_r <= loop_en ? mac_txd : 4'h0;
      lb_rx_dv_r <= loop_en && mac_tx_en;
      lb_rx_er_r <= loop_en && mac_tx_er;
    end
  end

  // ========================================================================
  // Mode outputs
  assign loop_en = ctrl_r[`PMR_B_LOOP];
  assign tp_tx_en = !loop_en && !low_power;
  assign tp_rx_en = !loop_en && !low_power;
  assign col_det_en = !loop_en || ctrl_r[`PMR_B_COLT];
  assign speed_100 = ctrl_r[`PMR_B_RATE];
  assign an_enable = ctrl_r[`PMR_B_ANEN];
  assign low_power = ctrl_r[`PMR_B_LPWR];
  assign isolate = ctrl_r[`PMR_B_ISO];
  assign duplex_full = ctrl_r[`PMR_B_DPX];
  assign an_restart_req = an_restart_r;
  assign soft_reset = srst_busy_r;

endmodule // pmr_mgmt_regs

`default_nettype wire

// file: pmr_mgmt_regs_chk.sv
// Port assertions for the management register bank
`timescale 1ns/1ps
`default_nettype none
module pmr_mgmt_regs_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic mac_tx_en,
  input wire logic an_started,
  input wire logic lb_rx_dv_r,
  input wire logic loop_en,
  input wire logic tp_tx_en,
  input wire logic tp_rx_en,
  input wire logic col_det_en,
  input wire logic speed_100,
  input wire logic an_enable,
  input wire logic low_power,
  input wire logic duplex_full,
  input wire logic an_restart_req,
  input wire logic soft_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence tx_in_loop;
    loop_en && mac_tx_en ##1 loop_en;
  endsequence
  sequence srst_start;
    $rose(soft_reset);
  endsequence
  // ====================================================
  // Loopback path
  loop_line_a: assert property (loop_en |-> !tp_tx_en && !tp_rx_en)
    else $error("line path active in loopback");
  col_keep_a: assert property (!loop_en |-> col_det_en)
    else $error("collision detect off outside loopback");
  lb_valid_a: assert property (tx_in_loop |-> lb_rx_dv_r)
    else $error("loopback receive valid late");
  lb_quiet_a: assert property ((!loop_en)[*2] |-> !lb_rx_dv_r)
    else $error("loopback receive valid without loopback");
  // ====================================================
  // Self-clearing controls
  srst_hold_a: assert property (srst_start |-> soft_reset[*8])
    else $error("software reset too short");
  srst_end_a: assert property (srst_start |-> ##[78:84] !soft_reset)
    else $error("software reset did not clear");
  srst_dflt_a: assert property ($fell(soft_reset) |-> speed_100 && an_enable
    && !loop_en && !low_power && !duplex_full && !an_restart_req)
    else $error("controls not at defaults after software reset");
  an_clear_a: assert property (an_restart_req && an_started |=> !an_restart_req)
    else $error("restart bit not cleared");
  an_need_a: assert property ($rose(an_restart_req) |-> an_enable)
    else $error("restart accepted with negotiation off");
endmodule // pmr_mgmt_regs_chk
`default_nettype wire

// file: pmr_sta_model.sv
// Station manager model that sends serial management frames
`timescale 1ns/1ps
`default_nettype none
module pmr_sta_model (
  input wire logic sys_clk,
  input wire logic mdio_in,
  output logic mdc,
  output logic sta_out,
  output logic sta_oe
);
  initial begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_oe = 1'b0;
  end
  // ====================================================
  // Frame; mdc half period of 5 cycles keeps above the 3-cycle minimum
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      mdc <= 1'b0;
      sta_out <= bits[63-i];
      sta_oe <= (op == 2'b01) || (i < 46);
      repeat (5) @(posedge sys_clk);
      if (i >= 48) begin
        rd = {rd[14:0], mdio_in};
      end
      mdc <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    mdc <= 1'b0;
    sta_oe <= 1'b0;
  endtask
endmodule // pmr_sta_model
`default_nettype wire

// file: test_pmr_mgmt_regs.sv
// Testbench for the management register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.vh"
module test_pmr_mgmt_regs;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] phy = 5'h01;
  logic [4:0] phy_addr_pin = 5'h01;
  logic ev_high = 1'b0;
  logic ev_low_n = 1'b1;
  logic [2:0] sm_state = 3'h0;
  logic an_started = 1'b0;
  logic [3:0] mac_txd = 4'h0;
  logic mac_tx_en = 1'b0;
  logic mac_tx_er = 1'b0;
  wire logic mdc, sta_out, sta_oe, mdio_out_r, mdio_oe_r, lb_rx_dv_r, lb_rx_er_r, loop_en;
  wire logic tp_tx_en, tp_rx_en, col_det_en, speed_100, an_enable, low_power, isolate;
  wire logic duplex_full, an_restart_req, soft_reset;
  wire logic [3:0] lb_rxd_r;
  // Released line floats to the pull-up level
  wire logic mdio_w = mdio_oe_r ? mdio_out_r : (sta_oe ? sta_out : 1'b1);
  int n_fail = 0;
  int checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  pmr_mgmt_regs u_pmr_mgmt_regs (.sys_clk, .arst_n, .mdc, .mdio_in(mdio_w), .mdio_out_r,
    .mdio_oe_r, .phy_addr_pin, .ev_high, .ev_low_n, .sm_state, .an_started, .mac_txd,
    .mac_tx_en, .mac_tx_er, .lb_rxd_r, .lb_rx_dv_r, .lb_rx_er_r, .loop_en, .tp_tx_en,
    .tp_rx_en, .col_det_en, .speed_100, .an_enable, .low_power, .isolate, .duplex_full,
    .an_restart_req, .soft_reset);
  pmr_sta_model u_pmr_sta_model (.sys_clk, .mdio_in(mdio_w), .mdc, .sta_out, .sta_oe);
  // ====================================================
  // Tasks
  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] wd);
    logic [15:0] v;
    u_pmr_sta_model.frame(`PMR_OP_WR, phy, `PMR_REG_CTRL, wd, v);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    u_pmr_sta_model.frame(`PMR_OP_RD, phy, ra, 16'h0000, v);
    chk(v, exp);
  endtask
  task automatic wait_sr(input logic lvl);
    int k;
    for (k = 0; k < 200 && soft_reset !== lvl; k++) @(posedge sys_clk);
    if (k == 200) begin
      chk(soft_reset, lvl);
      tally_and_finish();
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic pulse_ev(input logic [2:0] s);
    ev_high <= 1'b1;
    ev_low_n <= 1'b0;
    sm_state <= s;
    @(posedge sys_clk);
    ev_high <= 1'b0;
    ev_low_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  // ====================================================
  // Main sequence
  initial begin
    logic [15:0] v;
    do_reset();
    rd(`PMR_REG_CTRL, 16'h3000);
    rd(`PMR_REG_EVT, 16'h4000);
    rd(5'h05, 16'h0000);
    wr(16'h4080);
    chk({loop_en, tp_tx_en, tp_rx_en, col_det_en}, 16'h0009);
    mac_txd <= 4'ha;
    mac_tx_en <= 1'b1;
    mac_tx_er <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({lb_rx_er_r, lb_rx_dv_r, lb_rxd_r}, 16'h003a);
    mac_tx_en <= 1'b0;
    mac_tx_er <= 1'b0;
    wr(16'h4000);
    chk(col_det_en, 16'h0000);
    wr(16'h0200);
    mac_tx_en <= 1'b1;
    mac_tx_er <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({lb_rx_er_r, lb_rx_dv_r, lb_rxd_r}, 16'h0000);
    mac_tx_en <= 1'b0;
    mac_tx_er <= 1'b0;
    rd(`PMR_REG_CTRL, 16'h0000);
    wr(16'h1000);
    wr(16'h1200);
    chk(an_restart_req, 16'h0001);
    an_started <= 1'b1;
    repeat (2) @(posedge sys_clk);
    an_started <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(an_restart_req, 16'h0000);
    wr(16'h3100);
    chk({speed_100, an_enable, low_power, isolate, duplex_full}, 16'h0019);
    rd(`PMR_REG_CTRL, 16'h3100);
    u_pmr_sta_model.frame(`PMR_OP_WR, 5'h02, `PMR_REG_CTRL, 16'h0000, v);
    // Foreign address: the line must stay released, so the pull-up reads back
    u_pmr_sta_model.frame(`PMR_OP_RD, 5'h02, `PMR_REG_CTRL, 16'h0000, v);
    chk(v, 16'hffff);
    rd(`PMR_REG_CTRL, 16'h3100);
    pulse_ev(3'h5);
    sm_state <= 3'h2;
    rd(`PMR_REG_EVT, 16'h8005);
    sm_state <= 3'h1;
    rd(`PMR_REG_EVT, 16'h4002);
    rd(`PMR_REG_EVT, 16'h4001);
    ev_high <= 1'b1;
    rd(`PMR_REG_EVT, 16'hc001);
    ev_high <= 1'b0;
    rd(`PMR_REG_EVT, 16'hc001);
    pulse_ev(3'h1);
    wr(16'h3900);
    chk({low_power, tp_tx_en, tp_rx_en}, 16'h0004);
    rd(`PMR_REG_EVT, 16'h4001);
    rd(`PMR_REG_CTRL, 16'h3900);
    pulse_ev(3'h3);
    wr(16'h8000);
    wait_sr(1'b1);
    wait_sr(1'b0);
    rd(`PMR_REG_CTRL, 16'h3000);
    rd(`PMR_REG_EVT, 16'h4003);
    phy <= 5'h00;
    phy_addr_pin <= 5'h00;
    do_reset();
    chk(isolate, 16'h0001);
    rd(`PMR_REG_CTRL, 16'h3400);
    tally_and_finish();
  end
endmodule // test_pmr_mgmt_regs
bind pmr_mgmt_regs pmr_mgmt_regs_chk u_pmr_mgmt_regs_chk (.sys_clk, .arst_n, .mac_tx_en,
  .an_started, .lb_rx_dv_r, .loop_en, .tp_tx_en, .tp_rx_en, .col_det_en, .speed_100,
  .an_enable, .low_power, .duplex_full, .an_restart_req, .soft_reset);
`default_nettype wire
